// file: logic/ptah_top.sv
`timescale 1ns/1ps
`include "ptah_defs.svh"

// How it works
// - the address phase stores the pci address into the address register
// - a pci read raises attention asking add-on to write the data register
// - status outputs hold steady while attention is low; add-on samples them then
// - burst flag low for multi-phase accesses, high for single-phase ones
// - two-bit region number names the target region, 01 is region 1
// - direction output high for pci writes, low for pci reads
// - active-low byte lanes of the access shown; all zero means full word
// - address output strobe puts the address register on the add-on bus
// - selected write strobe at a rising edge latches the bus into data register
// - final done sampled drops attention at once, access ends the next clock
// - after a single access ends a new pci access is taken soon after
// - each burst word is captured, next phase starts only after done
// - the address register steps by one word for every burst phase after the first
// - done held low moves one word per clock through a burst
// - initiator wait states drop attention and bus data is not valid
// - wait states over, attention returns with the next burst word
// - selected read strobe drives the data register onto the add-on bus
// - after a burst ends, the next access waits two clocks past completion
module ptah_top #(
    parameter int ADR_W = 7
) (
    input  wire logic                     SYS_CLK_I,
    input  wire logic                     RST_I,
    input  wire logic                     PCI_START_I,
    input  wire ptah_pkg::ptah_word_t     PCI_ADDR_I,
    input  wire logic                     PCI_WRITE_I,
    input  wire logic                     PCI_MULTI_I,
    input  wire logic [`PTAH_REGION_W-1:0] PCI_REGION_I,
    input  wire logic [`PTAH_LANE_W-1:0]  PCI_BYTE_LANES_N_I,
    input  wire logic                     PCI_IRDY_I,
    input  wire ptah_pkg::ptah_word_t     PCI_WDATA_I,
    input  wire logic                     PCI_LAST_I,
    output logic                          PCI_ACCEPT_O,
    output logic                          PCI_PHASE_DONE_O,
    output ptah_pkg::ptah_word_t          PCI_RDATA_O,
    input  wire logic                     ADDRESS_OUTPUT_STROBE_N_I,
    input  wire logic                     ADDON_DONE_N_I,
    input  wire logic                     SELECT_N_I,
    input  wire logic [ADR_W-1:2]         ADR_I,
    input  wire logic [`PTAH_LANE_W-1:0]  BE_N_I,
    input  wire logic                     RD_N_I,
    input  wire logic                     WR_N_I,
    input  wire ptah_pkg::ptah_word_t     DQ_I,
    output ptah_pkg::ptah_word_t          DQ_O,
    output logic                          DQ_OE_O,
    output logic                          PASSTHRU_ATTENTION_N_O,
    output logic                          MULTI_PHASE_FLAG_N_O,
    output logic [`PTAH_REGION_W-1:0]     REGION_NUMBER_O,
    output logic                          WRITE_DIRECTION_O,
    output logic [`PTAH_LANE_W-1:0]       PASSTHRU_BYTE_LANES_N_O
);
    import ptah_pkg::*;

    localparam logic [ADR_W-1:0] DATA_OFF = `PTAH_DATA_OFF;

    // data register select; only word address bits take part
    function automatic logic reg_hit(input logic sel_n, input logic [ADR_W-1:2] adr);
        reg_hit = !sel_n && (adr == DATA_OFF[ADR_W-1:2]);
    endfunction

    ptah_state_t         state;
    ptah_state_t         next_state;
    logic                last_word;
    logic                multi_q;
    logic [1:0]          gap_cnt;
    ptah_word_t          addr_q;
    ptah_word_t          addr_next;
    ptah_word_t          data_q;
    ptah_word_t          data_next;

    wire logic           start_hit;
    wire logic           strobe_on;
    wire logic           rd_hit;
    wire logic           wr_hit;
    wire logic           atn_on;
    wire logic           done_seen;
    wire logic           wr_phase_done;
    wire logic           take_word;
    wire logic           incr_addr;
    wire logic           read_done;
    wire logic           write_done;
    wire logic           next_atn_n;
    wire logic           next_burst_n;
    wire logic           next_dq_oe;
    wire ptah_word_t     next_dq;
    wire logic [1:0]     next_gap;

    // a new access is only taken while the accept flag is shown
    assign start_hit = PCI_START_I && PCI_ACCEPT_O;

    // address strobe masks the register decode, so stray selects do nothing
    assign strobe_on = !ADDRESS_OUTPUT_STROBE_N_I;
    assign rd_hit    = !strobe_on && !RD_N_I && reg_hit(SELECT_N_I, ADR_I);
    assign wr_hit    = !strobe_on && !WR_N_I && reg_hit(SELECT_N_I, ADR_I);

    // completion counts only while attention is shown
    assign atn_on    = !PASSTHRU_ATTENTION_N_O;
    assign done_seen = atn_on && !ADDON_DONE_N_I && (state == ST_ACTIVE);

    // write path: a word completes on done; a new word loads if the initiator
    // has one and the slot is empty or just emptied, so done held low moves
    // one word per clock
    assign wr_phase_done = done_seen && WRITE_DIRECTION_O;
    assign take_word     = (state == ST_ACTIVE) && WRITE_DIRECTION_O && PCI_IRDY_I &&
                           (!atn_on || (wr_phase_done && !last_word));
    assign incr_addr     = wr_phase_done && !last_word;
    assign write_done    = wr_phase_done && last_word;
    assign read_done     = done_seen && !WRITE_DIRECTION_O;

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_hit) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (write_done || read_done) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                next_state = ST_GAP;
            end
            ST_GAP: begin
                if (gap_cnt == `PTAH_GAP_ONE) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // a burst needs one more idle clock than a single before the next access
    assign next_gap = (state == ST_FINISH) ?
                          (multi_q ? `PTAH_GAP_CYCLES : `PTAH_GAP_ONE) :
                      (state == ST_GAP) ? gap_cnt - `PTAH_GAP_ONE : gap_cnt;

    // attention: reads raise it with the address phase, writes while a word
    // sits in the data register; a write slot left empty is an initiator wait
    assign next_atn_n = (state == ST_IDLE)   ? !(start_hit && !PCI_WRITE_I) :
                        (state != ST_ACTIVE) ? 1'b1 :
                        (read_done || write_done) ? 1'b1 :
                        WRITE_DIRECTION_O ?
                            !(take_word || (atn_on && !wr_phase_done)) :
                            1'b0;

    // burst flag set by the address phase, cleared together with attention
    assign next_burst_n = (state == ST_IDLE) ? !(start_hit && PCI_MULTI_I) :
                          (next_state == ST_FINISH) ? 1'b1 : MULTI_PHASE_FLAG_N_O;

    // add-on bus drive; registered, so the word shows one clock after the
    // strobe, and the address wins over a read that breaks the strobe order
    assign next_dq_oe = strobe_on || rd_hit;
    assign next_dq    = strobe_on ? addr_next :
                        rd_hit    ? data_next : `PTAH_RST_WORD;

    // pass-through address register
    ptah_addr_reg u_addr (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .capture_i  (start_hit),
        .cap_addr_i (PCI_ADDR_I),
        .incr_i     (incr_addr),
        .q_o        (addr_q),
        .next_o     (addr_next)
    );

    // pass-through data register
    ptah_data_reg #(
        .DATA_W (`PTAH_WORD_W),
        .BE_W   (`PTAH_LANE_W)
    ) u_data (
        .clk_i       (SYS_CLK_I),
        .rst_i       (RST_I),
        .load_i      (take_word),
        .load_data_i (PCI_WDATA_I),
        .wr_i        (wr_hit),
        .wr_be_n_i   (BE_N_I),
        .wr_data_i   (DQ_I),
        .q_o         (data_q),
        .next_o      (data_next)
    );

    // state, gap count and word bookkeeping
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state     <= ST_IDLE;
            gap_cnt   <= 2'h0;
            last_word <= 1'b0;
            multi_q   <= 1'b0;
        end else begin
            state   <= next_state;
            gap_cnt <= next_gap;
            if (start_hit) begin
                multi_q <= PCI_MULTI_I;
            end
            // a single-phase access has only one word whatever the core says
            if (take_word) begin
                last_word <= PCI_LAST_I || !multi_q;
            end
        end
    end

    // handshake outputs toward add-on logic
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PASSTHRU_ATTENTION_N_O <= 1'b1;
            MULTI_PHASE_FLAG_N_O   <= 1'b1;
            DQ_OE_O                <= 1'b0;
            DQ_O                   <= `PTAH_RST_WORD;
        end else begin
            PASSTHRU_ATTENTION_N_O <= next_atn_n;
            MULTI_PHASE_FLAG_N_O   <= next_burst_n;
            DQ_OE_O                <= next_dq_oe;
            DQ_O                   <= next_dq;
        end
    end

    // status is caught only at the address phase, so it cannot move under
    // attention
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REGION_NUMBER_O         <= `PTAH_RST_REGION;
            WRITE_DIRECTION_O       <= 1'b0;
            PASSTHRU_BYTE_LANES_N_O <= `PTAH_RST_LANES;
        end else if (start_hit) begin
            REGION_NUMBER_O         <= PCI_REGION_I;
            WRITE_DIRECTION_O       <= PCI_WRITE_I;
            PASSTHRU_BYTE_LANES_N_O <= PCI_BYTE_LANES_N_I;
        end
    end

    // answers toward the pci core; read data includes a same-edge write
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PCI_ACCEPT_O     <= 1'b0;
            PCI_PHASE_DONE_O <= 1'b0;
            PCI_RDATA_O      <= `PTAH_RST_WORD;
        end else begin
            PCI_ACCEPT_O     <= (next_state == ST_IDLE);
            PCI_PHASE_DONE_O <= wr_phase_done || read_done;
            if (read_done) begin
                PCI_RDATA_O <= data_next;
            end
        end
    end

    // idle keeps both handshake outputs released
    idle_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (state == ST_IDLE) |-> PASSTHRU_ATTENTION_N_O && MULTI_PHASE_FLAG_N_O)
        else $error("attention or burst flag active while idle");

    // read request raises attention with read direction on the next clock
    read_request_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (start_hit && !PCI_WRITE_I) |=> !PASSTHRU_ATTENTION_N_O && !WRITE_DIRECTION_O)
        else $error("read access did not raise attention");

    // status outputs hold while attention stays low
    status_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (!PASSTHRU_ATTENTION_N_O ##1 !PASSTHRU_ATTENTION_N_O) |->
        $stable(REGION_NUMBER_O) && $stable(WRITE_DIRECTION_O) &&
        $stable(PASSTHRU_BYTE_LANES_N_O) && $stable(MULTI_PHASE_FLAG_N_O))
        else $error("status changed under attention");

    // final done drops attention at once and finishes next clock
    done_finish_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (read_done || write_done) |=> PASSTHRU_ATTENTION_N_O && MULTI_PHASE_FLAG_N_O &&
        (state == ST_FINISH) ##1 (state == ST_GAP))
        else $error("completion did not end the access");

    // without done a read stays pending
    read_pending_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (!PASSTHRU_ATTENTION_N_O && ADDON_DONE_N_I && !WRITE_DIRECTION_O) |=>
        !PASSTHRU_ATTENTION_N_O)
        else $error("pending read dropped without done");

    // address strobe drives the address register next clock
    addr_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !ADDRESS_OUTPUT_STROBE_N_I |=> DQ_OE_O && (DQ_O == addr_q))
        else $error("address strobe did not drive the address");

    // full-lane write stores the bus word
    data_latch_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (wr_hit && !take_word && BE_N_I == `PTAH_BE_FULL) |=> (data_q == $past(DQ_I)))
        else $error("data register write lost");

    // each further burst phase steps the address by one word
    burst_step_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        incr_addr |=> (addr_q == $past(addr_q) + `PTAH_ADDR_STEP))
        else $error("burst address not incremented");

    // initiator wait after a done leaves attention high
    wait_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (wr_phase_done && !last_word && !PCI_IRDY_I) |=> PASSTHRU_ATTENTION_N_O)
        else $error("attention held during initiator wait");

    // after a burst the next access is refused for two clocks past the finish clock
    reaccept_gap_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (state == ST_FINISH && multi_q) |-> !PCI_ACCEPT_O ##1 !PCI_ACCEPT_O ##1 !PCI_ACCEPT_O
        ##1 PCI_ACCEPT_O)
        else $error("new access accepted at the wrong clock");

    // after a single access only one clock past the finish clock is refused
    single_gap_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (state == ST_FINISH && !multi_q) |-> !PCI_ACCEPT_O ##1 !PCI_ACCEPT_O ##1 PCI_ACCEPT_O)
        else $error("single access accepted at the wrong clock");

    // address phase stores the pci address
    addr_capture_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        start_hit |=> (addr_q == $past(PCI_ADDR_I)))
        else $error("pci address not captured");

    // status is taken from the address phase
    status_load_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        start_hit |=> (MULTI_PHASE_FLAG_N_O == !$past(PCI_MULTI_I)) &&
        (REGION_NUMBER_O == $past(PCI_REGION_I)) && (WRITE_DIRECTION_O == $past(PCI_WRITE_I)) &&
        (PASSTHRU_BYTE_LANES_N_O == $past(PCI_BYTE_LANES_N_I)))
        else $error("status not taken from the address phase");

    // read strobe drives the data register next clock
    read_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        rd_hit |=> DQ_OE_O && (DQ_O == data_q))
        else $error("read strobe did not drive the data register");

    // a word loaded while attention is off brings attention back with it
    wait_return_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (take_word && !atn_on) |=> !PASSTHRU_ATTENTION_N_O && (data_q == $past(PCI_WDATA_I)))
        else $error("attention not raised with the next word");

endmodule

// file: logic/ptah_defs.svh
`ifndef PTAH_DEFS_SVH
`define PTAH_DEFS_SVH

// widths of the add-on pass-through port
`define PTAH_WORD_W      32
`define PTAH_LANE_W      4
`define PTAH_REGION_W    2

// register map on the add-on bus, byte offsets
`define PTAH_DATA_OFF    7'h2c

// reset values
`define PTAH_RST_WORD    32'h0000_0000
`define PTAH_RST_LANES   4'hf
`define PTAH_RST_REGION  2'h0

// all lanes enabled, active low
`define PTAH_BE_FULL     4'h0

// address step of one burst data phase, in bytes
`define PTAH_ADDR_STEP   32'h0000_0004

// idle clocks after the finishing clock before a new access is taken
`define PTAH_GAP_CYCLES  2'h2
`define PTAH_GAP_ONE     2'h1

`endif

// file: logic/ptah_pkg.sv
`include "ptah_defs.svh"

package ptah_pkg;

    // handshake sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_FINISH,
        ST_GAP
    } ptah_state_t;

    typedef logic [`PTAH_WORD_W-1:0] ptah_word_t;

    // address of the next burst data phase
    function automatic ptah_word_t ptah_step(input ptah_word_t addr);
        ptah_step = addr + `PTAH_ADDR_STEP;
    endfunction

endpackage

// file: logic/ptah_addr_reg.sv
`timescale 1ns/1ps
`include "ptah_defs.svh"

module ptah_addr_reg (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              capture_i,
    input  wire ptah_pkg::ptah_word_t cap_addr_i,
    input  wire logic              incr_i,
    output ptah_pkg::ptah_word_t   q_o,
    output ptah_pkg::ptah_word_t   next_o
);
    import ptah_pkg::*;

    // capture wins: a new address phase starts a fresh count
    assign next_o = capture_i ? cap_addr_i :
                    incr_i    ? ptah_step(q_o) : q_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= `PTAH_RST_WORD;
        end else begin
            q_o <= next_o;
        end
    end

endmodule

// file: logic/ptah_data_reg.sv
`timescale 1ns/1ps
`include "ptah_defs.svh"

module ptah_data_reg #(
    parameter int DATA_W = `PTAH_WORD_W,
    parameter int BE_W   = `PTAH_LANE_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              load_i,
    input  wire logic [DATA_W-1:0] load_data_i,
    input  wire logic              wr_i,
    input  wire logic [BE_W-1:0]   wr_be_n_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    output logic      [DATA_W-1:0] q_o,
    output logic      [DATA_W-1:0] next_o
);
    import ptah_pkg::*;

    localparam int LANE = DATA_W / BE_W;

    // pci side load has priority; add-on writes merge per enabled lane
    always_comb begin
        next_o = q_o;
        if (load_i) begin
            next_o = load_data_i;
        end else if (wr_i) begin
            for (int i = 0; i < BE_W; i++) begin
                if (!wr_be_n_i[i]) begin
                    next_o[i*LANE +: LANE] = wr_data_i[i*LANE +: LANE];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= `PTAH_RST_WORD;
        end else begin
            q_o <= next_o;
        end
    end

endmodule

// file: verif/ptah_addon_model.sv
`timescale 1ns/1ps

// add-on user logic on the far side of the pass-through port, behavioural
module ptah_addon_model (
    input  wire logic        clk_i,
    input  wire logic        attn_n_i,
    input  wire logic        burst_n_i,
    input  wire logic        dir_i,
    input  wire logic [1:0]  region_i,
    input  wire logic [3:0]  lanes_n_i,
    input  wire logic [31:0] dq_i,
    input  wire logic        dq_oe_i,
    input  wire logic        slow_i,
    input  wire logic        refetch_i,
    input  wire logic        bad_i,
    input  wire logic [31:0] supply_i,
    output logic             strobe_n_o,
    output logic             done_n_o,
    output logic             sel_n_o,
    output logic [4:0]       adr_o,
    output logic [3:0]       be_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic [31:0]      dq_o,
    output logic             got_tgl_o,
    output logic [33:0]      got_o
);
    int   nwords;
    logic cap;

    // hand one observed value to the bench; a toggle so back-to-back reports are seen
    task automatic report(input logic [1:0] kind, input logic [31:0] val);
        got_o     = {kind, dq_oe_i || kind == 2'h0 ? val : ~val};
        got_tgl_o = ~got_tgl_o;
    endtask

    // address fetch: strobe one clock, data shows one clock later
    task automatic fetch_addr;
        strobe_n_o = 1'b0;
        @(posedge clk_i);
        #1 strobe_n_o = 1'b1;
        @(posedge clk_i);
        report(2'h1, dq_i);
    endtask

    task automatic drive(input logic [4:0] adr, input logic [3:0] be_n, input logic [31:0] d,
                         input logic fin);
        sel_n_o  = 1'b0;
        adr_o    = adr;
        be_n_o   = be_n;
        dq_o     = d;
        wr_n_o   = 1'b0;
        done_n_o = ~fin;
    endtask

    // released data lines show the inverse of the last value so a stale sample is caught
    task automatic idle_bus;
        sel_n_o  = 1'b1;
        rd_n_o   = 1'b1;
        wr_n_o   = 1'b1;
        done_n_o = 1'b1;
        be_n_o   = 4'hf;
        dq_o     = ~dq_o;
    endtask

    initial begin
        strobe_n_o = 1'b1;
        adr_o      = 5'h00;
        dq_o       = 32'h0000_0000;
        got_tgl_o  = 1'b0;
        got_o      = '0;
        idle_bus();
        forever begin
            @(posedge clk_i);
            if (attn_n_i == 1'b0) begin
                report(2'h0, {24'h0, burst_n_i, region_i, dir_i, lanes_n_i});
                #1 fetch_addr();
                if (dir_i == 1'b0) begin
                    // the fetch edge itself leaves one quiet clock before any write
                    repeat (slow_i ? 2 : 0) @(posedge clk_i);
                    if (bad_i) begin
                        #1 drive(5'h0a, 4'h0, ~supply_i, 1'b0);
                        @(posedge clk_i);
                    end
                    #1 drive(5'h0b, bad_i ? 4'hc : 4'h0, supply_i, 1'b1);
                    @(posedge clk_i);
                    #1 idle_bus();
                end else begin
                    nwords = 0;
                    #1 sel_n_o = 1'b0;
                    adr_o  = 5'h0b;
                    rd_n_o = 1'b0;
                    repeat (400) begin
                        @(posedge clk_i);
                        cap = done_n_o == 1'b0 && attn_n_i == 1'b0;
                        if (cap) begin
                            report(2'h2, dq_i);
                            nwords++;
                        end
                        if (attn_n_i && burst_n_i) break;
                        #1;
                        if (cap && refetch_i && nwords == 2) begin
                            rd_n_o   = 1'b1;
                            done_n_o = 1'b1;
                            fetch_addr();
                            #1 rd_n_o = 1'b0;
                        end else begin
                            done_n_o = slow_i ? ~done_n_o : 1'b0;
                        end
                    end
                    #1 idle_bus();
                end
            end
        end
    end
endmodule

// file: verif/ptah_top_tb.sv
`timescale 1ns/1ps
`include "ptah_defs.svh"

`define PTAH_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end

module ptah_top_tb;
    logic sys_clk, rst, start, pwrite, pmulti, irdy, plast, slow, refetch, bad, got_tgl, seen;
    logic strobe_n, done_n, sel_n, rd_n, wr_n, accept, pdone, dq_oe, attn_n, burst_n, dir;
    logic [31:0] paddr, wdata, rdata, dq_in, dq_out, supply, prev;
    logic [1:0]  region, reg_o;
    logic [3:0]  lanes, be_n, lanes_o;
    logic [4:0]  adr;
    logic [33:0] got, notes[$];
    int seed = 57970;
    int miscompares = 0;
    int comparisons = 0;

    ptah_top #(.ADR_W(7)) u_ptah_top (
        .SYS_CLK_I(sys_clk), .RST_I(rst), .PCI_START_I(start), .PCI_ADDR_I(paddr),
        .PCI_WRITE_I(pwrite), .PCI_MULTI_I(pmulti), .PCI_REGION_I(region),
        .PCI_BYTE_LANES_N_I(lanes), .PCI_IRDY_I(irdy), .PCI_WDATA_I(wdata), .PCI_LAST_I(plast),
        .PCI_ACCEPT_O(accept), .PCI_PHASE_DONE_O(pdone), .PCI_RDATA_O(rdata),
        .ADDRESS_OUTPUT_STROBE_N_I(strobe_n), .ADDON_DONE_N_I(done_n), .SELECT_N_I(sel_n),
        .ADR_I(adr), .BE_N_I(be_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .DQ_I(dq_in), .DQ_O(dq_out),
        .DQ_OE_O(dq_oe), .PASSTHRU_ATTENTION_N_O(attn_n), .MULTI_PHASE_FLAG_N_O(burst_n),
        .REGION_NUMBER_O(reg_o), .WRITE_DIRECTION_O(dir), .PASSTHRU_BYTE_LANES_N_O(lanes_o));

    ptah_addon_model u_ptah_addon_model (
        .clk_i(sys_clk), .attn_n_i(attn_n), .burst_n_i(burst_n), .dir_i(dir), .region_i(reg_o),
        .lanes_n_i(lanes_o), .dq_i(dq_out), .dq_oe_i(dq_oe), .slow_i(slow), .refetch_i(refetch),
        .bad_i(bad), .supply_i(supply), .strobe_n_o(strobe_n), .done_n_o(done_n),
        .sel_n_o(sel_n), .adr_o(adr), .be_n_o(be_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .dq_o(dq_in), .got_tgl_o(got_tgl), .got_o(got));

    task automatic give_verdict;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // bounded wait step, always landing just after the rising edge
    task automatic step(inout int cnt);
        @(posedge sys_clk);
        #1;
        cnt++;
        if (cnt > 300) begin
            miscompares++;
            give_verdict();
        end
    endtask

    // oldest note against what appeared; an unexpected result is a mismatch
    task automatic take(input logic [33:0] g);
        logic [33:0] e;
        e = notes.size() == 0 ? ~g : notes.pop_front();
        `PTAH_CHK(g, e)
    endtask

    // watcher mid-cycle, so a report made on the rising edge is never raced
    always @(negedge sys_clk) begin
        if (got_tgl !== seen) begin
            seen = got_tgl;
            take(got);
        end
        if (pdone === 1'b1 && dir === 1'b0) begin
            take({2'h3, rdata});
        end
    end

    // one pci access; writes are always flagged multi-phase
    task automatic access(input logic wr, input int n, input logic [1:0] rg,
                          input logic [3:0] ln, input logic sl, input logic rf, input logic bd);
        logic [31:0] base;
        logic [31:0] w[$];
        logic        tk;
        int          idx;
        int          cnt;
        base = $random(seed) & 32'hffff_fffc;
        for (int k = 0; k < n; k++) w.push_back($random(seed));
        slow    = sl;
        refetch = rf;
        bad     = bd;
        supply  = w[0];
        notes.push_back({2'h0, 24'h0, ~wr, rg, wr, ln});
        notes.push_back({2'h1, base});
        for (int k = 0; k < n && wr; k++) begin
            notes.push_back({2'h2, w[k]});
            if (rf && k == 1) notes.push_back({2'h1, base + 32'h8});
        end
        // partial write keeps the upper half from before; lanes are per byte
        prev = wr ? w[n-1] : (bd ? {prev[31:16], w[0][15:0]} : w[0]);
        if (!wr) notes.push_back({2'h3, prev});
        cnt = 0;
        while (accept !== 1'b1) step(cnt);
        start  = 1'b1;
        paddr  = base;
        pwrite = wr;
        pmulti = wr;
        region = rg;
        lanes  = ln;
        step(cnt);
        start = 1'b0;
        paddr = ~base;
        idx   = 0;
        cnt   = 0;
        // initiator side: a word is taken on a done edge or while attention is off
        while (wr && idx <= n) begin
            irdy  = idx < n && ($random(seed) & 3) != 0;
            wdata = idx < n ? w[idx] : ~wdata;
            plast = idx == n - 1;
            if (idx == n) break;
            @(posedge sys_clk);
            tk = irdy && (attn_n === 1'b1 || done_n === 1'b0);
            #1;
            idx += tk;
            if (++cnt > 300) step(cnt);
        end
        cnt = 99;
        while (accept !== 1'b1) begin
            step(cnt);
            if (pdone === 1'b1) cnt = 0;
        end
        `PTAH_CHK(cnt, wr ? `PTAH_GAP_CYCLES + 1 : `PTAH_GAP_ONE + 1)
        $display("access done: write %0d, phases %0d, region %0d", wr, n, rg);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end

    initial begin
        {start, pwrite, pmulti, irdy, plast, slow, refetch, bad, seen} = '0;
        {paddr, wdata, supply, prev, region, lanes} = '0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        `PTAH_CHK({attn_n, burst_n, dq_oe}, 3'h6)
        // every region code, fast and slow done, one with a stray and a partial write
        for (int r = 0; r < 4; r++) begin
            access(1'b0, 1, r[1:0], 4'($random(seed)), r[0], 1'b0, r == 3);
        end
        access(1'b1, 6, 2'h1, `PTAH_BE_FULL, 1'b0, 1'b0, 1'b0);
        access(1'b1, 6, 2'h2, `PTAH_BE_FULL, 1'b1, 1'b1, 1'b0);
        access(1'b0, 1, 2'h1, `PTAH_BE_FULL, 1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge sys_clk);
        `PTAH_CHK(notes.size(), 0)
        give_verdict();
    end
endmodule
